// ==== verilog/dibu_defs.svh ====
`ifndef DIBU_DEFS_SVH
`define DIBU_DEFS_SVH
// Debug register codes
`define DIBU_R_CFG_STAT    5'h00
`define DIBU_R_BGND_ATTR   5'h05
`define DIBU_R_ATTR0       5'h06
`define DIBU_R_TRIG_DEF    5'h07
`define DIBU_R_PC_BP0      5'h08
`define DIBU_R_PC_MASK     5'h09
`define DIBU_R_ADDR_HI0    5'h0C
`define DIBU_R_ADDR_LO0    5'h0D
`define DIBU_R_DATA_BP0    5'h0E
`define DIBU_R_DATA_MASK0  5'h0F
`define DIBU_R_ATTR1       5'h16
`define DIBU_R_XTRIG_DEF   5'h17
`define DIBU_R_PC_BP1      5'h18
`define DIBU_R_PC_BP2      5'h1A
`define DIBU_R_PC_BP3      5'h1B
`define DIBU_R_ADDR_HI1    5'h1C
`define DIBU_R_ADDR_LO1    5'h1D
`define DIBU_R_DATA_BP1    5'h1E
`define DIBU_R_DATA_MASK1  5'h1F
`define DIBU_RST_ZERO      32'h0000_0000
`define DIBU_RST_ATTR      32'h0000_0005
// Field positions
`define DIBU_RESP_HI       31
`define DIBU_RESP_LO       30
`define DIBU_MAP_BIT       4
`define DIBU_EN_ADDR_BIT   2
`define DIBU_EN_DATA_BIT   3
`define DIBU_FRAME_EMU_BIT 17
// Status, vectors, timing
`define DIBU_STAT_DBG      4'hD
`define DIBU_STAT_L1_HIT   4'h4
`define DIBU_STAT_NONE     4'h0
`define DIBU_ENTRY_CYC     3'h3
`define DIBU_VEC_PC_BP     12'h034
`define DIBU_VEC_OTHER_BP  12'h030
`define DIBU_VEC_AUTO      12'h060
`define DIBU_LVL_NMI       3'h7
// Serial command set
`define DIBU_CMD_WRITE     11'h164
`define DIBU_RESP_DONE     17'h0FFFF
`define DIBU_RESP_BUSY     17'h00000
`define DIBU_RESP_ILLEGAL  17'h1FFFF
`define DIBU_PKT_LAST      5'h10
`endif

// ==== verilog/dibu_pkg.sv ====
package dibu_pkg;
   typedef enum logic [1:0] {
      DIBU_RSP_TRACE, DIBU_RSP_HALT, DIBU_RSP_IRQ, DIBU_RSP_RSVD
   } dibu_resp_e;
   typedef enum logic [1:0] {DIBU_SER_CMD, DIBU_SER_HI, DIBU_SER_LO} dibu_ser_e;
   typedef enum logic {DIBU_EX_RUN, DIBU_EX_ENTRY} dibu_ex_e;
   typedef struct packed {
      logic [31:0]       cfg_stat;
      logic [31:0]       bgnd_attr;
      logic [31:0]       trig_def;
      logic [31:0]       xtrig_def;
      logic [1:0][31:0]  attr;
      logic [3:0][31:0]  pc_bp;
      logic [31:0]       pc_mask;
      logic [1:0][31:0]  addr_hi;
      logic [1:0][31:0]  addr_lo;
      logic [1:0][31:0]  data_bp;
      logic [1:0][31:0]  data_mask;
   } dibu_bank_s;
   typedef struct packed {
      logic [31:0] pc;
      logic        pc_valid;
      logic [31:0] addr;
      logic [31:0] data;
      logic        op_valid;
   } dibu_bus_s;
   typedef struct packed {
      logic        clk_m, clk_s, clk_p, din_m, din_s;
      logic [4:0]  cnt;
      logic [16:0] rx, tx;
      logic        sdo, rx_valid, load;
   } dibu_ser_s;
   typedef struct packed {
      logic pc_hit, op_hit;
   } dibu_match_s;
endpackage

// ==== verilog/dibu_serial.sv ====
`timescale 1ns/1ps
`include "dibu_defs.svh"
module dibu_serial import dibu_pkg::*; (
   input  logic        ref_clk,
   input  logic        sys_rst,
   input  logic        serial_clk,
   input  logic        serial_in,
   input  logic [16:0] resp,
   output logic        rx_valid,
   output logic [16:0] rx_word,
   output logic        serial_out
);
   dibu_ser_s r_reg, r_next;
   always_comb begin
      r_next = r_reg;
      r_next.clk_m = serial_clk;
      r_next.clk_s = r_reg.clk_m;
      r_next.clk_p = r_reg.clk_s;
      r_next.din_m = serial_in;
      r_next.din_s = r_reg.din_m;
      r_next.rx_valid = 1'b0;
      r_next.load = r_reg.rx_valid;
      if (r_reg.load) begin
         r_next.tx = resp;
         r_next.sdo = resp[16];
      end else if (r_reg.clk_s && !r_reg.clk_p) begin
         r_next.rx = {r_reg.rx[15:0], r_reg.din_s};
         r_next.tx = {r_reg.tx[15:0], 1'b0};
         r_next.sdo = r_reg.tx[15];
         if (r_reg.cnt == `DIBU_PKT_LAST) begin
            r_next.cnt = 5'h00;
            r_next.rx_valid = 1'b1;
         end else begin
            r_next.cnt = r_reg.cnt + 5'h01;
         end
      end
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
   assign rx_valid = r_reg.rx_valid;
   assign rx_word = r_reg.rx;
   assign serial_out = r_reg.sdo;
endmodule

// ==== verilog/dibu_match.sv ====
`timescale 1ns/1ps
`include "dibu_defs.svh"
module dibu_match import dibu_pkg::*; (
   input  logic       ref_clk,
   input  logic       sys_rst,
   input  dibu_bank_s bank,
   input  dibu_bus_s  bus,
   output logic       pc_hit,
   output logic       op_hit
);
   dibu_match_s m_reg, m_next;
   logic [3:0]  pc_vec;
   logic [1:0]  op_vec;
   logic [31:0] en_word [2];
   assign en_word[0] = bank.trig_def;
   assign en_word[1] = bank.xtrig_def;
   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_pc
         logic [31:0] msk;
         assign msk = (i == 0) ? bank.pc_mask : 32'h0000_0000;
         // Set mask bits are don't-care; bit 0 is the valid bit
         assign pc_vec[i] = bus.pc_valid && bank.pc_bp[i][0] &&
            (((bus.pc ^ bank.pc_bp[i]) & ~msk) >> 1) == 32'h0;
      end
      for (i = 0; i < 2; i++) begin : g_op
         logic a_ok, d_ok;
         assign a_ok = !en_word[i][`DIBU_EN_ADDR_BIT] ||
            (bus.addr >= bank.addr_lo[i] && bus.addr <= bank.addr_hi[i]);
         assign d_ok = !en_word[i][`DIBU_EN_DATA_BIT] ||
            ((bus.data ^ bank.data_bp[i]) & ~bank.data_mask[i]) == 32'h0;
         assign op_vec[i] = bus.op_valid && a_ok && d_ok &&
            (en_word[i][`DIBU_EN_ADDR_BIT] || en_word[i][`DIBU_EN_DATA_BIT]);
      end
   endgenerate
   always_comb begin
      m_next.pc_hit = |pc_vec;
      m_next.op_hit = |op_vec;
   end
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end
   assign pc_hit = m_reg.pc_hit;
   assign op_hit = m_reg.op_hit;
endmodule

// ==== verilog/dibu_top.sv ====
// Operation
// - Trigger response: trace only, halt, interrupt.
// - Trigger state always shown on trace bus.
// - Debug interrupt outranks all normal interrupts.
// - Optional separate address space in debug routine.
// - Hidden emulator bit; interrupt mask left alone.
// - Debug entry drives status 0xD, sets emulator.
// - Normal interrupts sampled once per instruction.
// - Non-debug exception saves, then clears emulator bit.
// - Saved bit goes to frame bit 17.
// - Return with bit set re-enters emulator, 0xD.
// - Four 32-bit program counter breakpoints.
// - Second data breakpoint, mask, address bounds.
// - Set mask bits are don't-care; pc mask covers breakpoint 0 only.
// - Register write replaces all 32 bits.
// - Writes from serial channel or supervisor instruction.
// - Register code selects target, reserved codes listed.
// - Return 0x0FFFF once register write completes.
// - Program counter matches ORed into one trigger.
// - Vector 0x034 for pc, else 0x030.
`timescale 1ns/1ps
`include "dibu_defs.svh"
module dibu_top import dibu_pkg::*; (
   input  logic        ref_clk,
   input  logic        sys_rst,
   input  logic        debug_serial_clock,
   input  logic        dbg_serial_in,
   output logic        dbg_serial_out,
   input  logic        cpu_wr_valid,
   input  logic        cpu_wr_supervisor,
   input  logic [4:0]  cpu_wr_code,
   input  logic [31:0] cpu_wr_data,
   input  dibu_bus_s   core_bus,
   input  logic [3:0]  core_status,
   input  logic [2:0]  core_ipl,
   input  logic [2:0]  core_imask,
   input  logic        instr_done,
   input  logic        exc_ack,
   input  logic        exception_return,
   input  logic [31:0] return_fs_word,
   input  logic        halt_resume,
   output logic [3:0]  processor_status_code,
   output logic [7:0]  trace_status_data_bus,
   output logic        dbg_halt,
   output logic        exc_req,
   output logic [11:0] exc_vec_off,
   output logic [31:0] frame_fs_word,
   output logic        emu_mode,
   output logic        emu_space_sel
);

   typedef struct packed {
      dibu_bank_s  bank;
      dibu_ser_e   ser;
      logic [4:0]  code;
      logic [15:0] op_hi;
      logic [16:0] resp;
      logic        emu;
      logic        dbg_pend;
      logic        dbg_pc;
      logic        irq_pend;
      logic [2:0]  irq_lvl;
      dibu_ex_e    ex;
      logic [2:0]  cnt;
      logic        exc_req;
      logic        exc_dbg;
      logic [11:0] exc_vec;
      logic [31:0] frame;
      logic        halt;
      logic [3:0]  stat;
      logic [7:0]  trace;
      logic        space;
   } dibu_top_s;

   dibu_top_s  s_reg;
   dibu_top_s  s_next;
   logic       ser_valid;
   logic [16:0] ser_word;
   logic       pc_hit;
   logic       op_hit;
   logic       ser_wr;
   logic       cpu_wr;
   logic       wr_en;
   logic [4:0] wr_code;
   logic [31:0] wr_data;
   logic       trig;
   dibu_resp_e resp_kind;
   logic       irq_set;

   dibu_serial u_serial (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .serial_clk (debug_serial_clock),
      .serial_in  (dbg_serial_in),
      .resp       (s_reg.resp),
      .rx_valid   (ser_valid),
      .rx_word    (ser_word),
      .serial_out (dbg_serial_out)
   );

   dibu_match u_match (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .bank    (s_reg.bank),
      .bus     (core_bus),
      .pc_hit  (pc_hit),
      .op_hit  (op_hit)
   );

   // Write source select; serial wins a same-cycle clash
   assign ser_wr = ser_valid && (s_reg.ser == DIBU_SER_LO);
   assign cpu_wr = cpu_wr_valid && cpu_wr_supervisor && !ser_wr;
   assign wr_en = ser_wr || cpu_wr;
   assign wr_code = ser_wr ? s_reg.code : cpu_wr_code;
   assign wr_data = ser_wr ? {s_reg.op_hi, ser_word[15:0]} : cpu_wr_data;

   assign resp_kind =
      dibu_resp_e'(s_reg.bank.trig_def[`DIBU_RESP_HI:`DIBU_RESP_LO]);
   assign trig = pc_hit || op_hit;
   assign irq_set = instr_done && (core_ipl != 3'h0) &&
      ((core_ipl > core_imask) || (core_ipl == `DIBU_LVL_NMI));

   always_comb begin
      s_next = s_reg;

      // Serial command decoder: command, high word, low word
      if (ser_valid) begin
         unique case (s_reg.ser)
            DIBU_SER_CMD: begin
               if (!ser_word[16] && ser_word[15:5] == `DIBU_CMD_WRITE) begin
                  s_next.code = ser_word[4:0];
                  s_next.ser = DIBU_SER_HI;
                  s_next.resp = `DIBU_RESP_BUSY;
               end else begin
                  s_next.resp = `DIBU_RESP_ILLEGAL;
               end
            end
            DIBU_SER_HI: begin
               s_next.op_hi = ser_word[15:0];
               s_next.ser = DIBU_SER_LO;
               s_next.resp = `DIBU_RESP_BUSY;
            end
            DIBU_SER_LO: begin
               s_next.ser = DIBU_SER_CMD;
               s_next.resp = `DIBU_RESP_DONE;
            end
            default: begin
               s_next.ser = DIBU_SER_CMD;
            end
         endcase
      end

      // Register bank write, whole longword
      if (wr_en) begin
         case (wr_code)
            `DIBU_R_CFG_STAT:   s_next.bank.cfg_stat = wr_data;
            `DIBU_R_BGND_ATTR:  s_next.bank.bgnd_attr = wr_data;
            `DIBU_R_ATTR0:      s_next.bank.attr[0] = wr_data;
            `DIBU_R_TRIG_DEF:   s_next.bank.trig_def = wr_data;
            `DIBU_R_PC_BP0:     s_next.bank.pc_bp[0] = wr_data;
            `DIBU_R_PC_MASK:    s_next.bank.pc_mask = wr_data;
            `DIBU_R_ADDR_HI0:   s_next.bank.addr_hi[0] = wr_data;
            `DIBU_R_ADDR_LO0:   s_next.bank.addr_lo[0] = wr_data;
            `DIBU_R_DATA_BP0:   s_next.bank.data_bp[0] = wr_data;
            `DIBU_R_DATA_MASK0: s_next.bank.data_mask[0] = wr_data;
            `DIBU_R_ATTR1:      s_next.bank.attr[1] = wr_data;
            `DIBU_R_XTRIG_DEF:  s_next.bank.xtrig_def = wr_data;
            `DIBU_R_PC_BP1:     s_next.bank.pc_bp[1] = wr_data;
            `DIBU_R_PC_BP2:     s_next.bank.pc_bp[2] = wr_data;
            `DIBU_R_PC_BP3:     s_next.bank.pc_bp[3] = wr_data;
            `DIBU_R_ADDR_HI1:   s_next.bank.addr_hi[1] = wr_data;
            `DIBU_R_ADDR_LO1:   s_next.bank.addr_lo[1] = wr_data;
            `DIBU_R_DATA_BP1:   s_next.bank.data_bp[1] = wr_data;
            `DIBU_R_DATA_MASK1: s_next.bank.data_mask[1] = wr_data;
            default: begin
               // Reserved code: write dropped
               s_next.bank = s_reg.bank;
            end
         endcase
      end

      // Exception handshake with the core
      if (exc_ack && s_reg.exc_req) begin
         s_next.exc_req = 1'b0;
         if (s_reg.exc_dbg) begin
            // Mask level is untouched on debug entry
            s_next.emu = 1'b1;
            s_next.ex = DIBU_EX_ENTRY;
            s_next.cnt = `DIBU_ENTRY_CYC;
            s_next.dbg_pend = 1'b0;
         end else begin
            // Old emulator bit into frame, then leave emulator mode
            s_next.frame = 32'h0000_0000;
            s_next.frame[`DIBU_FRAME_EMU_BIT] = s_reg.emu;
            s_next.emu = 1'b0;
            s_next.irq_pend = 1'b0;
         end
      end else if (!s_reg.exc_req && s_reg.ex == DIBU_EX_RUN) begin
         if (s_reg.dbg_pend) begin
            s_next.exc_req = 1'b1;
            s_next.exc_dbg = 1'b1;
            s_next.exc_vec = s_reg.dbg_pc ? `DIBU_VEC_PC_BP
                                          : `DIBU_VEC_OTHER_BP;
         end else if (s_reg.irq_pend) begin
            s_next.exc_req = 1'b1;
            s_next.exc_dbg = 1'b0;
            s_next.exc_vec = `DIBU_VEC_AUTO + {7'h00, s_reg.irq_lvl, 2'b00};
         end
      end

      // Exception return with frame bit 17 set enters emulator mode; a clear bit leaves it as is
      if (exception_return && return_fs_word[`DIBU_FRAME_EMU_BIT]) begin
         s_next.emu = 1'b1;
         s_next.ex = DIBU_EX_ENTRY;
         s_next.cnt = `DIBU_ENTRY_CYC;
      end

      // Status 0xD held for the entry cycles
      if (s_reg.ex == DIBU_EX_ENTRY) begin
         if (s_reg.cnt == 3'h1) begin
            s_next.ex = DIBU_EX_RUN;
            s_next.cnt = 3'h0;
         end else begin
            s_next.cnt = s_reg.cnt - 3'h1;
         end
         if (exception_return && return_fs_word[`DIBU_FRAME_EMU_BIT]) begin
            s_next.ex = DIBU_EX_ENTRY;
            s_next.cnt = `DIBU_ENTRY_CYC;
         end
      end

      // Set wins over clear for pending events
      if (irq_set) begin
         s_next.irq_pend = 1'b1;
         s_next.irq_lvl = core_ipl;
      end
      if (trig && resp_kind == DIBU_RSP_IRQ) begin
         s_next.dbg_pend = 1'b1;
         s_next.dbg_pc = pc_hit;
      end
      if (halt_resume) begin
         s_next.halt = 1'b0;
      end
      if (trig && resp_kind == DIBU_RSP_HALT) begin
         s_next.halt = 1'b1;
      end

      // Trace: marker plus state nibble on every trigger
      if (s_next.ex == DIBU_EX_ENTRY || trig) begin
         s_next.stat = `DIBU_STAT_DBG;
      end else begin
         s_next.stat = core_status;
      end
      s_next.trace = {s_next.stat,
                      trig ? `DIBU_STAT_L1_HIT : `DIBU_STAT_NONE};
      s_next.space = s_next.emu &&
                     s_reg.bank.cfg_stat[`DIBU_MAP_BIT];
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '0;
         s_reg.bank.cfg_stat <= `DIBU_RST_ZERO;
         s_reg.bank.bgnd_attr <= `DIBU_RST_ATTR;
         s_reg.bank.attr[0] <= `DIBU_RST_ATTR;
         s_reg.bank.attr[1] <= `DIBU_RST_ATTR;
         s_reg.bank.trig_def <= `DIBU_RST_ZERO;
         s_reg.bank.xtrig_def <= `DIBU_RST_ZERO;
         s_reg.ser <= DIBU_SER_CMD;
         s_reg.ex <= DIBU_EX_RUN;
      end else begin
         s_reg <= s_next;
      end
   end

   assign processor_status_code = s_reg.stat;
   assign trace_status_data_bus = s_reg.trace;
   assign dbg_halt = s_reg.halt;
   assign exc_req = s_reg.exc_req;
   assign exc_vec_off = s_reg.exc_vec;
   assign frame_fs_word = s_reg.frame;
   assign emu_mode = s_reg.emu;
   assign emu_space_sel = s_reg.space;

endmodule

// ==== verification/dibu_host_model.sv ====
`timescale 1ns/1ps
`include "dibu_defs.svh"
module dibu_host_model import dibu_pkg::*; (
   output logic debug_serial_clock,
   output logic dbg_serial_in,
   input  logic dbg_serial_out
);
   // Clock idles low outside frames
   initial begin
      debug_serial_clock = 1'h0;
      dbg_serial_in      = 1'h1;
   end

   task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
      #7;
      for (int i = 16; i >= 0; i--) begin
         dbg_serial_in = tx[i];
         #200 debug_serial_clock = 1'h1;
         rx[i] = dbg_serial_out;
         #200 debug_serial_clock = 1'h0;
      end
      // Released line shows the inverse of the last bit
      dbg_serial_in = ~tx[0];
   endtask

   task automatic wr_reg(input logic [4:0]  code,
                         input logic [31:0] d,
                         output logic [16:0] st);
      logic [16:0] r;
      xfer({1'h0, `DIBU_CMD_WRITE, code}, r);
      xfer({1'h0, d[31:16]}, r);
      xfer({1'h0, d[15:0]}, r);
      xfer(17'h00000, st);
   endtask
endmodule

// ==== verification/dibu_checker.sv ====
`timescale 1ns/1ps
module dibu_checker import dibu_pkg::*; (
   input logic        ref_clk,
   input logic        sys_rst,
   input logic [3:0]  core_status,
   input logic        exc_ack,
   input logic        exception_return,
   input logic [31:0] return_fs_word,
   input logic [3:0]  processor_status_code,
   input logic [7:0]  trace_status_data_bus,
   input logic        exc_req,
   input logic [11:0] exc_vec_off,
   input logic [31:0] frame_fs_word,
   input logic        emu_mode,
   input logic        emu_space_sel
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   sequence s_entry;
      ##[0:1] processor_status_code == 4'hD;
   endsequence
   sequence s_dbg_ack;
      exc_req && exc_ack && (exc_vec_off inside {12'h030, 12'h034});
   endsequence

   AST_EMU_ENTRY: assert property (
      s_dbg_ack |=> emu_mode ##0 s_entry)
      else $error("debug entry did not set emulator mode");
   AST_IRQ_SAVE: assert property (
      exc_req && exc_ack && exc_vec_off >= 12'h060 |=>
         !emu_mode && frame_fs_word[17] == $past(emu_mode))
      else $error("emulator bit not saved and cleared");
   AST_RET: assert property (
      exception_return && return_fs_word[17] |=> emu_mode ##0 s_entry)
      else $error("return did not resume emulator mode");
   AST_SPACE: assert property (
      emu_space_sel |-> emu_mode || $past(emu_mode))
      else $error("separate space outside emulator mode");
   AST_REQ_HOLD: assert property (
      exc_req && !exc_ack |=> exc_req && $stable(exc_vec_off))
      else $error("exception request dropped before ack");
   AST_VEC: assert property (
      exc_req |-> (exc_vec_off inside {12'h030, 12'h034})
         || (exc_vec_off[11:5] == 7'h03 && exc_vec_off[1:0] == 2'h0))
      else $error("exception vector offset out of range");
   AST_TRACE: assert property (
      $rose(exc_req) && exc_vec_off == 12'h034 |->
         $past(trace_status_data_bus) == 8'hD4)
      else $error("trigger not shown on trace bus");
   AST_STAT: assert property (
      processor_status_code == $past(core_status)
         || processor_status_code == 4'hD)
      else $error("status neither passed through nor debug");
endmodule

bind dibu_top dibu_checker u_chk (.ref_clk, .sys_rst, .core_status,
   .exc_ack, .exception_return, .return_fs_word, .processor_status_code,
   .trace_status_data_bus, .exc_req, .exc_vec_off, .frame_fs_word,
   .emu_mode, .emu_space_sel);

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`include "dibu_defs.svh"
module testbench import dibu_pkg::*; ;
   logic        ref_clk, sys_rst, debug_serial_clock, dbg_serial_in;
   logic        dbg_serial_out, cpu_wr_valid, cpu_wr_supervisor;
   logic        instr_done, exc_ack, exception_return, halt_resume;
   logic        dbg_halt, exc_req, emu_mode, emu_space_sel;
   logic [4:0]  cpu_wr_code;
   logic [31:0] cpu_wr_data, return_fs_word, frame_fs_word;
   logic [3:0]  core_status, processor_status_code;
   logic [2:0]  core_ipl, core_imask;
   logic [7:0]  trace_status_data_bus;
   logic [11:0] exc_vec_off;
   dibu_bus_s   core_bus;
   int          failures = 0;
   int          checked = 0;
   int          cyc = 0;

   dibu_top DUT (.ref_clk, .sys_rst, .debug_serial_clock, .dbg_serial_in,
      .dbg_serial_out, .cpu_wr_valid, .cpu_wr_supervisor, .cpu_wr_code,
      .cpu_wr_data, .core_bus, .core_status, .core_ipl, .core_imask,
      .instr_done, .exc_ack, .exception_return, .return_fs_word,
      .halt_resume, .processor_status_code, .trace_status_data_bus,
      .dbg_halt, .exc_req, .exc_vec_off, .frame_fs_word, .emu_mode,
      .emu_space_sel);
   dibu_host_model u_host (.debug_serial_clock, .dbg_serial_in,
      .dbg_serial_out);

   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic pulse(ref logic sig);
      @(negedge ref_clk);
      sig = 1'h1;
      @(negedge ref_clk);
      sig = 1'h0;
   endtask

   task automatic pc_hit(input logic [31:0] pc, input logic irq);
      @(negedge ref_clk);
      core_bus.pc = pc;
      core_bus.pc_valid = 1'h1;
      @(negedge ref_clk);
      core_bus.pc_valid = 1'h0;
      instr_done = irq;
      @(negedge ref_clk);
      instr_done = 1'h0;
   endtask

   task automatic cpu_wr(input logic [4:0] c, input logic [31:0] d,
                         input logic s);
      @(negedge ref_clk);
      cpu_wr_valid = 1'h1;
      cpu_wr_supervisor = s;
      cpu_wr_code = c;
      cpu_wr_data = d;
      @(negedge ref_clk);
      cpu_wr_valid = 1'h0;
   endtask

   task automatic op_ref(input logic [31:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      core_bus.addr = a;
      core_bus.data = d;
      core_bus.op_valid = 1'h1;
      @(negedge ref_clk);
      core_bus.op_valid = 1'h0;
   endtask

   task automatic wait_req();
      for (int i = 0; i < 20 && exc_req !== 1'h1; i++) @(negedge ref_clk);
      chk("exc_req", 32'h1, exc_req);
   endtask

   task automatic t_serial();
      logic [16:0] st;
      u_host.wr_reg(`DIBU_R_TRIG_DEF, 32'h8000_0000, st);
      chk("done", {15'h0, `DIBU_RESP_DONE}, {15'h0, st});
      u_host.wr_reg(`DIBU_R_PC_BP1, 32'h0000_1001, st);
      chk("done", {15'h0, `DIBU_RESP_DONE}, {15'h0, st});
      u_host.wr_reg(5'h19, 32'hFFFF_FFFF, st);
      chk("reserved", {15'h0, `DIBU_RESP_DONE}, {15'h0, st});
      u_host.wr_reg(`DIBU_R_CFG_STAT, 32'h0000_0010, st);
      // The status-fetch packet above was no command: illegal reply next
      u_host.xfer(17'h00000, st);
      chk("illegal", {15'h0, `DIBU_RESP_ILLEGAL}, {15'h0, st});
      $display("t_serial done");
   endtask

   task automatic t_debug();
      core_ipl = 3'h3;
      pc_hit(32'h0000_1000, 1'h1);
      wait_req();
      chk("vec", 32'h034, exc_vec_off);
      pulse(exc_ack);
      chk("emu", 32'h1, emu_mode);
      chk("space", 32'h1, emu_space_sel);
      chk("status", 32'hD, processor_status_code);
      pulse(instr_done);
      wait_req();
      chk("irq vec", 32'h06C, exc_vec_off);
      pulse(exc_ack);
      chk("frame", 32'h1, frame_fs_word[17]);
      chk("emu", 32'h0, emu_mode);
      core_ipl = 3'h0;
      return_fs_word = 32'h0002_0000;
      pulse(exception_return);
      chk("emu", 32'h1, emu_mode);
      chk("status", 32'hD, processor_status_code);
      $display("t_debug done");
   endtask

   task automatic t_cpu();
      logic seen;
      int   n;
      seen = 1'h0;
      n = 0;
      // Let the re-entry status run out before the mid-run reset
      for (int i = 0; i < 5; i++) begin
         if (processor_status_code === `DIBU_STAT_DBG) n++;
         @(negedge ref_clk);
      end
      chk("entry cycles", {29'h0, `DIBU_ENTRY_CYC}, n);
      sys_rst = 1'h1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'h0;
      core_status = 4'h1;
      cpu_wr(`DIBU_R_TRIG_DEF, 32'h4000_0000, 1'h1);
      cpu_wr(`DIBU_R_PC_BP0, 32'h0000_3001, 1'h0);
      pc_hit(32'h0000_3000, 1'h0);
      repeat (4) @(negedge ref_clk);
      chk("halt", 32'h0, dbg_halt);
      cpu_wr(`DIBU_R_PC_BP0, 32'h0000_3001, 1'h1);
      cpu_wr(`DIBU_R_PC_MASK, 32'h0000_00F0, 1'h1);
      pc_hit(32'h0000_30F0, 1'h0);
      repeat (2) @(negedge ref_clk);
      chk("halt", 32'h1, dbg_halt);
      pulse(halt_resume);
      chk("halt", 32'h0, dbg_halt);
      cpu_wr(`DIBU_R_TRIG_DEF, 32'h0000_0000, 1'h1);
      pc_hit(32'h0000_3000, 1'h0);
      for (int i = 0; i < 6; i++) begin
         if (trace_status_data_bus === 8'hD4) seen = 1'h1;
         @(negedge ref_clk);
      end
      chk("trace", 32'h1, seen);
      chk("req", 32'h0, {dbg_halt, exc_req});
      $display("t_cpu done");
   endtask

   task automatic t_operand();
      cpu_wr(`DIBU_R_TRIG_DEF, 32'h8000_0000, 1'h1);
      cpu_wr(`DIBU_R_XTRIG_DEF, 32'h0000_000C, 1'h1);
      cpu_wr(`DIBU_R_ADDR_LO1, 32'h0000_2000, 1'h1);
      cpu_wr(`DIBU_R_ADDR_HI1, 32'h0000_20FF, 1'h1);
      cpu_wr(`DIBU_R_DATA_BP1, 32'h1234_5678, 1'h1);
      cpu_wr(`DIBU_R_DATA_MASK1, 32'h0000_00FF, 1'h1);
      // Differs outside the masked byte: must not trigger
      op_ref(32'h0000_2080, 32'h1235_56AA);
      repeat (4) @(negedge ref_clk);
      chk("op miss", 32'h0, exc_req);
      op_ref(32'h0000_2080, 32'h1234_56AA);
      wait_req();
      chk("op vec", 32'h030, exc_vec_off);
      pulse(exc_ack);
      chk("emu", 32'h1, emu_mode);
      $display("t_operand done");
   endtask

   initial begin
      sys_rst = 1'h1;
      {cpu_wr_valid, cpu_wr_supervisor, instr_done, exc_ack} = 4'h0;
      {exception_return, halt_resume, core_ipl, core_imask} = 8'h00;
      cpu_wr_code = 5'h00;
      cpu_wr_data = 32'h0;
      return_fs_word = 32'h0;
      core_status = 4'h0;
      core_bus = '0;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'h0;
      t_serial();
      t_debug();
      t_cpu();
      t_operand();
      print_verdict();
   end
endmodule
